// ==== shared/oscx_pkg.sv ====
// Purpose: constants and types shared by the output signal conditioning block
// Assumes: 10 MHz system clock, 32-bit register port
// Notes: register offsets are byte addresses of 32-bit words
package oscx_pkg;
  // Detector sample width
  localparam int DW = 24;
  // Register offsets
  localparam logic [7:0] A_CH0 = 8'h00;
  localparam logic [7:0] A_CH1 = 8'h04;
  localparam logic [7:0] A_DCFG = 8'h08;
  localparam logic [7:0] A_CMD = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_STAMP0 = 8'h14;
  localparam logic [7:0] A_STAMP1 = 8'h18;
  localparam logic [7:0] A_ZERO0 = 8'h1C;
  localparam logic [7:0] A_ZERO1 = 8'h20;
  localparam logic [7:0] A_DOUT0 = 8'h24;
  localparam logic [7:0] A_DOUT1 = 8'h28;
  // Channel config fields
  localparam int F_GAIN = 0;
  localparam int F_SRC = 4;
  localparam int F_FAST = 7;
  localparam int F_PEND = 8;
  // Digital config fields
  localparam int F_RATE = 0;
  localparam int F_ZINIT = 4;
  localparam int F_COMP = 8;
  // Command bits
  localparam int C_ZERO = 0;
  localparam int C_REC0 = 2;
  localparam int C_REC1 = 3;
  localparam int C_CLRREF = 4;
  // Reset values: test pattern on both channels, 20 Hz digital rate
  localparam logic [31:0] CH_RST = 32'h0000_0070;
  localparam logic [31:0] DCFG_RST = 32'h0000_0004;
  // Gain ceilings
  localparam logic [3:0] GAIN_MAX = 4'hD;
  localparam logic [3:0] LIM_THERM = 4'h6;
  localparam logic [3:0] LIM_AIN = 4'h7;
  // Digital rates and analog filter timing
  localparam logic [3:0] RATE_N = 4'hC;
  localparam int FILT_HZ = 200;
  localparam int FAST_SH = 2;
  localparam int STD_SH = 4;
  // Detector kinds
  typedef enum logic [1:0] {DT_OTHER = 2'h0, DT_THERM = 2'h1, DT_ECAP = 2'h2, DT_AIN = 2'h3} oscx_dtype_t;
  // Analog channel sources
  typedef enum logic [2:0] {
    SRC_FRONT = 3'h0, SRC_BACK = 3'h1, SRC_FMC = 3'h2, SRC_C1F = 3'h3,
    SRC_C1B = 3'h4, SRC_C1A1 = 3'h5, SRC_C1A2 = 3'h6, SRC_TEST = 3'h7
  } oscx_src_t;
  // Profile recorder states
  typedef enum logic [2:0] {RS_IDLE = 3'b001, RS_ARMED = 3'b010, RS_REC = 3'b100} oscx_rec_t;

  // Cycles per digital sample; rates held in tenths of a hertz
  function automatic longint unsigned rate_div(input logic [3:0] idx, input longint unsigned clk_hz);
    longint unsigned dhz;
    case (idx)
      4'h0: dhz = 5000;
      4'h1: dhz = 2000;
      4'h2: dhz = 1000;
      4'h3: dhz = 500;
      4'h4: dhz = 200;
      4'h5: dhz = 100;
      4'h6: dhz = 50;
      4'h7: dhz = 20;
      4'h8: dhz = 10;
      4'h9: dhz = 5;
      4'hA: dhz = 2;
      default: dhz = 1;
    endcase
    return (clk_hz * 10) / dhz;
  endfunction : rate_div
endpackage : oscx_pkg

// ==== src/oscx_lpf.sv ====
// Purpose: first-order low-pass for one analog output
// Assumes: i_tick at the filter rate
// Notes: shift sets bandwidth, fast or standard
`timescale 1ns/1ps
module oscx_lpf import oscx_pkg::*; #(
  parameter int W = DW
) (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_fast,
  // Data
  input wire logic signed [W-1:0] i_x,
  output logic signed [W-1:0] o_y
);
  if (W < 8) begin : g_bad_w
    $error("oscx_lpf: width too small");
  end
  logic signed [W:0] diff; // Step toward input
  logic signed [W:0] next_y;

  // Step is a fraction of the error, so the result never leaves the range
  always_comb begin
    diff = (W + 1)'(i_x) - (W + 1)'(o_y);
    next_y = (W + 1)'(o_y) + (i_fast ? (diff >>> FAST_SH) : (diff >>> STD_SH));
  end

  // Filter state
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_y <= '0;
    end else if (i_ce && i_tick) begin
      o_y <= next_y[W-1:0];
    end
  end
endmodule : oscx_lpf

// ==== src/oscx_prof.sv ====
// Purpose: storage for two bleed-profile arrays
// Assumes: one word holds all four detector curves at one index
// Notes: both arrays read every cycle, one cycle late
`timescale 1ns/1ps
module oscx_prof import oscx_pkg::*; #(
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  // Write side
  input wire logic i_wr_en,
  input wire logic i_wr_arr,
  input wire logic [AW-1:0] i_idx,
  input wire logic [4*DW-1:0] i_wr_data,
  // Read side
  output logic [4*DW-1:0] o_rd0,
  output logic [4*DW-1:0] o_rd1
);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("oscx_prof: bad depth");
  end
  // Array 0 in lower half, array 1 in upper half
  logic [4*DW-1:0] mem [2*DEPTH];

  // Record writes
  always_ff @(posedge i_clk_sys) begin
    if (i_ce && i_wr_en) begin
      mem[{i_wr_arr, i_idx}] <= i_wr_data;
    end
  end

  // Playback reads of both arrays
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rd0 <= '0;
      o_rd1 <= '0;
    end else if (i_ce) begin
      o_rd0 <= mem[{1'b0, i_idx}];
      o_rd1 <= mem[{1'b1, i_idx}];
    end
  end
endmodule : oscx_prof

// ==== src/oscx_top.sv ====
// Purpose: conditions detector signals for two analog and digital outputs
// Assumes: detector inputs synchronous to i_clk_sys, run and events from sequencer
// Notes: register port has no wait states; read data valid one cycle later
// Overview of operation
// - Analog gain 0..13 multiplies by two-power
// - Gain applies on both analog channels
// - Gain capped by source detector kind
// - Gain reloads from pending field on event
// - Analog bandwidth fast or standard speed
// - Fast option chosen per channel
// - Zero latches level, subtracts from samples
// - Store event holds value, output unchanged
// - Rezero sets offset current minus held
// - Digital rate from twelve fixed values
// - Rate change refused during run
// - Init offset latched when enabled
// - Init offset touches digital path only
// - Recording writes zeros for absent detectors
// - Two arrays; analog uses first only
// - Curve per detector subtracted per sample
// - Analog source selector choices
// - Valid flag and stamp after recording
// - Analog value minus zero before gain
// - Two independently assigned channels
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module oscx_top import oscx_pkg::*; #(
  parameter int unsigned CLK_HZ = 10_000_000,
  parameter int DEPTH = 4096
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Detectors: front, back, aux 1, aux 2
  input wire logic signed [DW-1:0] i_det_front,
  input wire logic signed [DW-1:0] i_det_back,
  input wire logic signed [DW-1:0] i_det_aux1,
  input wire logic signed [DW-1:0] i_det_aux2,
  input wire logic [3:0] i_det_on,
  input wire logic [7:0] i_det_kind,
  // Run and run-table events, one bit per channel
  input wire logic i_run,
  input wire logic [1:0] i_evt_zero,
  input wire logic [1:0] i_evt_store,
  input wire logic [1:0] i_evt_rezero,
  input wire logic [1:0] i_evt_gain,
  input wire logic [31:0] i_stamp,
  // Outputs
  output logic signed [DW-1:0] o_ana0,
  output logic signed [DW-1:0] o_ana1,
  output logic signed [DW-1:0] o_dig0,
  output logic signed [DW-1:0] o_dig1,
  output logic o_dig_valid
);
  // Room for a 32-bit zero plus a shift of 13 with no wrap ahead of the clamp
  localparam int XW = DW + 24;
  localparam int AW = $clog2(DEPTH);
  localparam int unsigned FILT_DIV = CLK_HZ / FILT_HZ;
  if (CLK_HZ < 4 * FILT_HZ || DEPTH < 2) begin : g_bad_par
    $error("oscx_top: clock or depth unsupported");
  end

  // Sign-extend a sample to working width
  function automatic logic signed [XW-1:0] sx(input logic signed [DW-1:0] v);
    return {{(XW - DW){v[DW-1]}}, v};
  endfunction : sx
  // Clamp a working value to sample range
  function automatic logic signed [DW-1:0] sat(input logic signed [XW-1:0] v);
    if (v > sx({1'b0, {(DW - 1){1'b1}}})) return {1'b0, {(DW - 1){1'b1}}};
    if (v < sx({1'b1, {(DW - 1){1'b0}}})) return {1'b1, {(DW - 1){1'b0}}};
    return v[DW-1:0];
  endfunction : sat
  // Detector feeding a source
  function automatic logic [1:0] src_det(input oscx_src_t s);
    case (s)
      SRC_BACK, SRC_C1B: return 2'h1;
      SRC_C1A1: return 2'h2;
      SRC_C1A2: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction : src_det

  // Registers
  logic [31:0] ch_cfg [2]; // Gain, source, fast, pending gain
  logic [31:0] dcfg; // Rate, init offset, compensation selects
  logic signed [31:0] ana_zero [2]; // Analog zero setpoints
  logic [1:0] comp_valid; // Profile arrays hold good data
  logic [31:0] stamp [2]; // Time stamp per array
  logic rate_ref; // Sticky: rate write refused
  // Timing
  logic [31:0] rate_cnt;
  logic [31:0] filt_cnt;
  logic rate_tick;
  logic filt_tick;
  logic [7:0] test_ph; // Test pattern phase
  logic [AW-1:0] idx; // Sample index within run
  // Recorder
  oscx_rec_t rec_st;
  logic rec_arr;
  logic rec_ovf;
  logic [4*DW-1:0] prof0, prof1, wr_data;
  logic wr_en;
  // Datapath
  logic signed [DW-1:0] det [4];
  logic signed [XW-1:0] sv [2], dig_raw [2], av [2], store_val [2], rz_val [2];
  logic [3:0] geff [2];
  logic signed [DW-1:0] ana_in [2], ana_out [2], dout [2];
  logic signed [XW-1:0] dzero [2], held [2], ioff [2];
  logic zinit_d;
  logic [1:0] zero_cmd;
  logic cmd_wr, rate_bad;

  assign det[0] = i_det_front;
  assign det[1] = i_det_back;
  assign det[2] = i_det_aux1;
  assign det[3] = i_det_aux2;
  assign cmd_wr = i_wr && (i_addr == A_CMD);
  assign zero_cmd = i_evt_zero | ({2{cmd_wr}} & i_wdata[C_ZERO+:2]);
  assign rate_bad = i_run || (i_wdata[F_RATE+:4] >= RATE_N);
  assign rate_tick = (rate_cnt >= 32'(rate_div(dcfg[F_RATE+:4], CLK_HZ) - 1));
  assign filt_tick = (filt_cnt == 32'(FILT_DIV - 1));

  // Register writes and gain events
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ch_cfg[0] <= CH_RST;
      ch_cfg[1] <= CH_RST;
      dcfg <= DCFG_RST;
      ana_zero[0] <= '0;
      ana_zero[1] <= '0;
    end else if (i_ce) begin
      if (i_wr) begin
        if (i_addr == A_CH0) begin
          ch_cfg[0] <= i_wdata;
        end else if (i_addr == A_CH1) begin
          ch_cfg[1] <= i_wdata;
        end else if (i_addr == A_DCFG) begin
          // Rate field frozen during a run or for codes off the list
          dcfg <= {i_wdata[31:4], rate_bad ? dcfg[F_RATE+:4] : i_wdata[F_RATE+:4]};
        end else if (i_addr == A_ZERO0) begin
          ana_zero[0] <= i_wdata;
        end else if (i_addr == A_ZERO1) begin
          ana_zero[1] <= i_wdata;
        end
      end
      for (int c = 0; c < 2; c++) begin
        if (i_evt_gain[c]) begin
          ch_cfg[c][F_GAIN+:4] <= ch_cfg[c][F_PEND+:4];
        end
      end
    end
  end

  // Refused-rate flag; a new refusal beats the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rate_ref <= 1'b0;
    end else if (i_ce) begin
      rate_ref <= (rate_ref && !(cmd_wr && i_wdata[C_CLRREF])) || (i_wr && i_addr == A_DCFG && rate_bad);
    end
  end

  // Sample and filter timebases; sample clock restarts at run start when a recording is armed
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rate_cnt <= '0;
      filt_cnt <= '0;
      test_ph <= '0;
      idx <= '0;
    end else if (i_ce) begin
      rate_cnt <= (rate_tick || (i_run && idx == '0 && !rate_tick && rec_st == RS_ARMED)) ? '0 : rate_cnt + 1;
      filt_cnt <= filt_tick ? '0 : filt_cnt + 1;
      if (filt_tick) begin
        test_ph <= test_ph + 8'h01;
      end
      if (!i_run) begin
        idx <= '0;
      end else if (rate_tick && idx != {AW{1'b1}} && rec_st != RS_ARMED) begin
        idx <= idx + 1'b1;
      end
    end
  end

  // Source selection, gain cap, offsets
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      oscx_src_t s;
      logic [1:0] d;
      logic [3:0] lim;
      logic signed [XW-1:0] comp;
      lim = GAIN_MAX;
      comp = '0;
      s = oscx_src_t'(ch_cfg[c][F_SRC+:3]);
      d = src_det(s);
      case (s)
        SRC_FRONT, SRC_BACK: sv[c] = sx(det[d]);
        SRC_FMC: sv[c] = sx(det[0]) - sx(prof0[0+:DW]);
        SRC_TEST: sv[c] = XW'({test_ph, 8'h00});
        default: sv[c] = sx(prof0[d*DW+:DW]);
      endcase
      case (oscx_dtype_t'(i_det_kind[d*2+:2]))
        DT_THERM, DT_ECAP: lim = LIM_THERM;
        DT_AIN: lim = LIM_AIN;
        default: lim = GAIN_MAX;
      endcase
      if (s == SRC_TEST) lim = GAIN_MAX;
      geff[c] = (ch_cfg[c][F_GAIN+:4] > lim) ? lim : ch_cfg[c][F_GAIN+:4];
      av[c] = sv[c] - XW'(ana_zero[c]);
      case (dcfg[F_COMP+2*c+:2])
        2'h1: comp = sx(prof0[d*DW+:DW]);
        2'h2: comp = sx(prof1[d*DW+:DW]);
        default: comp = '0;
      endcase
      if (s != SRC_FRONT && s != SRC_BACK) comp = '0;
      dig_raw[c] = sv[c] - comp;
      store_val[c] = dig_raw[c] - dzero[c];
      rz_val[c] = dig_raw[c] - held[c];
    end
  end

  // Analog scale and clamp ahead of the filter
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ana_in[0] <= '0;
      ana_in[1] <= '0;
    end else if (i_ce) begin
      for (int c = 0; c < 2; c++) begin
        ana_in[c] <= sat(av[c] <<< geff[c]);
      end
    end
  end

  // Bandwidth filter per analog channel
  for (genvar c = 0; c < 2; c++) begin : g_lpf
    oscx_lpf #(.W(DW)) u_lpf (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_tick(filt_tick),
      .i_fast(ch_cfg[c][F_FAST]),
      .i_x(ana_in[c]),
      .o_y(ana_out[c])
    );
  end
  assign o_ana0 = ana_out[0];
  assign o_ana1 = ana_out[1];

  // Digital offsets: zero, store, rezero, init offset; zero beats rezero
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      zinit_d <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        dzero[c] <= '0;
        held[c] <= '0;
        ioff[c] <= '0;
      end
    end else if (i_ce) begin
      zinit_d <= dcfg[F_ZINIT];
      for (int c = 0; c < 2; c++) begin
        if (zero_cmd[c]) begin
          dzero[c] <= dig_raw[c];
        end else if (i_evt_rezero[c]) begin
          dzero[c] <= rz_val[c];
        end
        if (i_evt_store[c]) begin
          held[c] <= store_val[c];
        end
        // Only the digital stream sees this offset
        if (dcfg[F_ZINIT] && !zinit_d) begin
          ioff[c] <= dig_raw[c];
        end else if (!dcfg[F_ZINIT]) begin
          ioff[c] <= '0;
        end
      end
    end
  end

  // Digital samples at the selected rate
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      dout[0] <= '0;
      dout[1] <= '0;
      o_dig_valid <= 1'b0;
    end else if (i_ce) begin
      o_dig_valid <= rate_tick;
      if (rate_tick) begin
        for (int c = 0; c < 2; c++) begin
          dout[c] <= sat(dig_raw[c] - dzero[c] - ioff[c]);
        end
      end
    end
  end
  assign o_dig0 = dout[0];
  assign o_dig1 = dout[1];

  // Profile record word, absent or idle detectors as zero
  always_comb begin
    for (int d = 0; d < 4; d++) begin
      wr_data[d*DW+:DW] = i_det_on[d] ? det[d] : '0;
    end
  end
  assign wr_en = (rec_st == RS_REC) && rate_tick && !rec_ovf;

  oscx_prof #(.DEPTH(DEPTH), .AW(AW)) u_prof (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_wr_en(wr_en),
    .i_wr_arr(rec_arr),
    .i_idx(idx),
    .i_wr_data(wr_data),
    .o_rd0(prof0),
    .o_rd1(prof1)
  );

  // Recorder: armed by command, records one whole run; overflow fails it
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rec_st <= RS_IDLE;
      rec_arr <= 1'b0;
      rec_ovf <= 1'b0;
      comp_valid <= 2'b00;
      stamp[0] <= '0;
      stamp[1] <= '0;
    end else if (i_ce) begin
      case (rec_st)
        RS_IDLE: begin
          if (cmd_wr && (i_wdata[C_REC0] || i_wdata[C_REC1])) begin
            rec_arr <= i_wdata[C_REC1];
            rec_st <= RS_ARMED;
          end
        end
        RS_ARMED: begin
          if (i_run) begin
            rec_ovf <= 1'b0;
            comp_valid[rec_arr] <= 1'b0;
            rec_st <= RS_REC;
          end
        end
        RS_REC: begin
          if (rate_tick && idx == {AW{1'b1}}) begin
            rec_ovf <= 1'b1;
          end
          if (!i_run) begin
            if (!rec_ovf) begin
              comp_valid[rec_arr] <= 1'b1;
              stamp[rec_arr] <= i_stamp;
            end
            rec_st <= RS_IDLE;
          end
        end
        default: rec_st <= RS_IDLE;
      endcase
    end
  end

  // Register reads; data stands for one cycle only
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        if (i_addr == A_CH0) o_rdata <= ch_cfg[0];
        else if (i_addr == A_CH1) o_rdata <= ch_cfg[1];
        else if (i_addr == A_DCFG) o_rdata <= dcfg;
        else if (i_addr == A_STAT) o_rdata <= {27'h0, rate_ref, i_run, rec_st == RS_REC, comp_valid};
        else if (i_addr == A_STAMP0) o_rdata <= stamp[0];
        else if (i_addr == A_STAMP1) o_rdata <= stamp[1];
        else if (i_addr == A_ZERO0) o_rdata <= ana_zero[0];
        else if (i_addr == A_ZERO1) o_rdata <= ana_zero[1];
        else if (i_addr == A_DOUT0) o_rdata <= 32'(dout[0]);
        else if (i_addr == A_DOUT1) o_rdata <= 32'(dout[1]);
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  chk_gain_cap: assert property (oscx_dtype_t'(i_det_kind[1:0]) == DT_THERM && ch_cfg[0][F_SRC+:3] == 3'h0
    |-> geff[0] <= LIM_THERM) else $error("gain above detector ceiling");
  chk_gain_evt: assert property (i_ce && i_evt_gain[0] && !(i_wr && i_addr == A_CH0)
    |=> ch_cfg[0][F_GAIN+:4] == $past(ch_cfg[0][F_PEND+:4])) else $error("gain event not applied");
  chk_zero_latch: assert property (i_ce && zero_cmd[0] |=> dzero[0] == $past(dig_raw[0]))
    else $error("zero level not latched");
  chk_store_hold: assert property (i_ce && i_evt_store[0] && !rate_tick
    |=> held[0] == $past(store_val[0]) && $stable(dout[0])) else $error("store changed output");
  chk_rezero_off: assert property (i_ce && i_evt_rezero[0] && !zero_cmd[0]
    |=> dzero[0] == $past(rz_val[0])) else $error("rezero offset wrong");
  chk_rate_hold: assert property (i_run |=> $stable(dcfg[F_RATE+:4]))
    else $error("rate changed in run");
  chk_init_off: assert property (i_ce && dcfg[F_ZINIT] && !zinit_d |=> ioff[0] == $past(dig_raw[0]))
    else $error("init offset not latched");
  chk_rec_zero: assert property (wr_en && !i_det_on[0] |-> wr_data[0+:DW] == '0)
    else $error("absent detector not zero");
  chk_valid_stamp: assert property ($rose(comp_valid[0]) |-> stamp[0] == $past(i_stamp))
    else $error("valid without stamp");
  cov_zero: cover property (i_ce && zero_cmd[0] ##1 rate_tick);
  cov_rec_done: cover property ($rose(comp_valid[1]));
  cov_refused: cover property ($rose(rate_ref));
endmodule : oscx_top

// ==== bench/oscx_rec_model.sv ====
// Purpose: data system model that takes each digital sample pair
// Assumes: sample valid is a one-cycle strobe on the system clock
// Notes: counter wraps; the bench only looks for changes in it
`timescale 1ns/1ps
module oscx_rec_model import oscx_pkg::*; (
  // Clock
  input wire logic i_clk_sys,
  // Digital stream from the device
  input wire logic i_dig_valid,
  input wire logic signed [DW-1:0] i_dig0,
  input wire logic signed [DW-1:0] i_dig1,
  // Captured samples
  output logic signed [DW-1:0] o_s0,
  output logic signed [DW-1:0] o_s1,
  output logic [15:0] o_cnt
);
  // Start from a known count so the first change is seen
  initial o_cnt = 16'h0000;
  // Take a pair only on the strobe, as a real recorder would
  always @(posedge i_clk_sys) begin
    if (i_dig_valid) begin
      o_s0 <= i_dig0;
      o_s1 <= i_dig1;
      o_cnt <= o_cnt + 16'h0001;
    end
  end
endmodule : oscx_rec_model

// ==== bench/oscx_tb_top.sv ====
// Purpose: self-checking bench for the conditioning block
// Assumes: shortened clock parameter so rates and filters settle fast
// Notes: analog checks allow the filter's few-count undershoot
`timescale 1ns/1ps
module oscx_tb_top import oscx_pkg::*;;
  localparam int CLK = 20000;
  logic i_clk_sys = 1'b0;
  logic i_srst, i_ce, i_wr, i_rd, i_run;
  logic [7:0] i_addr, i_det_kind;
  logic [31:0] i_wdata, i_stamp, o_rdata;
  logic [3:0] i_det_on;
  logic [1:0] i_evt_zero, i_evt_store, i_evt_rezero, i_evt_gain;
  logic signed [DW-1:0] i_det_front, i_det_back, i_det_aux1, i_det_aux2;
  logic signed [DW-1:0] o_ana0, o_ana1, o_dig0, o_dig1, s0, s1;
  logic o_dig_valid;
  logic [15:0] cnt;
  int fails = 0;
  int n_tests = 0;
  int f, d, n;
  // Rates in tenths of a hertz, then analog cases: kind, gain, value, zero, result
  int dhz[5] = '{5000, 2000, 1000, 500, 200};
  int tk[5] = '{0, 1, 3, 2, 0};
  int tg[5] = '{3, 13, 9, 8, 13};
  int tv[5] = '{100, 10, 10, 5, 4096};
  int tz[5] = '{20, 0, 0, 0, 0};
  int te[5] = '{640, 640, 1280, 320, 8388607};

  oscx_top #(.CLK_HZ(CLK), .DEPTH(16)) oscx_top_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_det_front(i_det_front), .i_det_back(i_det_back), .i_det_aux1(i_det_aux1), .i_det_aux2(i_det_aux2),
    .i_det_on(i_det_on), .i_det_kind(i_det_kind), .i_run(i_run), .i_evt_zero(i_evt_zero),
    .i_evt_store(i_evt_store), .i_evt_rezero(i_evt_rezero), .i_evt_gain(i_evt_gain), .i_stamp(i_stamp),
    .o_ana0(o_ana0), .o_ana1(o_ana1), .o_dig0(o_dig0), .o_dig1(o_dig1), .o_dig_valid(o_dig_valid));
  oscx_rec_model oscx_rec_model_i (.i_clk_sys(i_clk_sys), .i_dig_valid(o_dig_valid), .i_dig0(o_dig0),
    .i_dig1(o_dig1), .o_s0(s0), .o_s1(s1), .o_cnt(cnt));

  // 10 MHz clock
  always #50 i_clk_sys = ~i_clk_sys;
  // Aux detectors carry noise that must never leak into front/back paths
  always @(posedge i_clk_sys) begin
    i_det_aux1 <= DW'($urandom);
    i_det_aux2 <= DW'($urandom);
  end

  // Verdict, the only exit
  task automatic summarize();
    $display("mismatches %0d of %0d compares", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // Fast filter creeps up to within 3 counts of its input
  task automatic near(input logic signed [DW-1:0] g, input int e);
    n_tests++;
    if ((g <= e && g >= e - 3) !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    cmp(o_rdata & m, e);
  endtask : rd
  // Wait for the recorder to take one more sample; n gets the gap
  task automatic waitc();
    logic [15:0] c0;
    c0 = cnt;
    n = 0;
    while (cnt === c0) begin
      @(posedge i_clk_sys);
      n++;
      if (n > 5000) begin
        fails++;
        summarize();
      end
    end
  endtask : waitc
  // Two samples, so an event just before a tick is surely visible
  task automatic smp2();
    waitc();
    waitc();
  endtask : smp2
  // 0 zero, 1 store, 2 rezero on channel 0; 3 gain load on both
  task automatic evt(input int k);
    @(posedge i_clk_sys);
    i_evt_zero <= {1'b0, k == 0};
    i_evt_store <= {1'b0, k == 1};
    i_evt_rezero <= {1'b0, k == 2};
    i_evt_gain <= {2{k == 3}};
    @(posedge i_clk_sys);
    i_evt_zero <= 2'h0;
    i_evt_store <= 2'h0;
    i_evt_rezero <= 2'h0;
    i_evt_gain <= 2'h0;
  endtask : evt
  task automatic rst();
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_srst <= 1'b0;
  endtask : rst
  // One short profile run, well under the shortened depth
  task automatic run();
    i_run <= 1'b1;
    repeat (300) @(posedge i_clk_sys);
    i_run <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask : run

  initial begin
    void'($urandom(32'hC80A));
    {i_srst, i_wr, i_rd, i_run, i_addr, i_wdata, i_det_kind} = '0;
    {i_evt_zero, i_evt_store, i_evt_rezero, i_evt_gain} = '0;
    {i_det_front, i_det_back, i_det_aux1, i_det_aux2} = '0;
    i_ce = 1'b1;
    i_det_on = 4'hF;
    i_stamp = $urandom;
    f = $urandom_range(60000, 4000);
    d = $urandom_range(3000, 1);
    rst();
    // Reset values and an unmapped hole
    rd(A_CH0, '1, CH_RST);
    rd(A_DCFG, '1, DCFG_RST);
    rd(8'h3C, '1, 32'h0);
    // Zero, store and rezero on the digital stream
    wr(A_DCFG, 32'h0);
    wr(A_CH0, 32'h0);
    i_det_front <= DW'(f);
    smp2();
    cmp(32'(s0), f);
    evt(0);
    smp2();
    cmp(32'(s0), 0);
    evt(1);
    smp2();
    cmp(32'(s0), 0);
    i_det_front <= DW'(f + d);
    smp2();
    cmp(32'(s0), d);
    evt(2);
    smp2();
    cmp(32'(s0), 0);
    // Sample periods for the fastest rates
    for (int i = 0; i < 5; i++) begin
      wr(A_DCFG, i);
      waitc();
      waitc();
      waitc();
      cmp(n, CLK * 10 / dhz[i]);
    end
    // Out-of-table code, then a change in mid-run
    wr(A_DCFG, 32'hC);
    rd(A_DCFG, 32'hF, 32'h4);
    rd(A_STAT, 32'h10, 32'h10);
    wr(A_CMD, 32'h10);
    i_run <= 1'b1;
    wr(A_DCFG, 32'h0);
    rd(A_DCFG, 32'hF, 32'h4);
    rd(A_STAT, 32'h18, 32'h18);
    i_run <= 1'b0;
    // Initial offset, kept on through the analog cases
    rst();
    wr(A_CH0, 32'h0);
    wr(A_DCFG, 32'h10);
    smp2();
    cmp(32'(s0), 0);
    i_det_front <= DW'(f + d + 5);
    smp2();
    cmp(32'(s0), 5);
    // Analog gain, ceilings, zero and clamp; channel 1 follows the back source
    for (int i = 0; i < 5; i++) begin
      i_det_kind <= 8'(tk[i] * 5);
      i_det_front <= DW'(tv[i]);
      i_det_back <= DW'(tv[i]);
      wr(A_ZERO0, tz[i]);
      wr(A_ZERO1, tz[i]);
      wr(A_CH0, 32'h80 | (tg[i] << 8));
      wr(A_CH1, 32'h90 | (tg[i] << 8));
      evt(3);
      n = 0;
      while ((o_ana0 <= te[i] && o_ana0 >= te[i] - 3 && o_ana1 <= te[i] && o_ana1 >= te[i] - 3) !== 1'b1
          && n < 12000) begin
        @(posedge i_clk_sys);
        n++;
      end
      near(o_ana0, te[i]);
      near(o_ana1, te[i]);
      rd(A_CH0, 32'hFFF, 32'h80 | (tg[i] * 257));
    end
    wr(A_DCFG, 32'h0);
    smp2();
    cmp(32'(s0), 4096);
    // Profile records: array 0 with all on, array 1 with front off
    rst();
    wr(A_DCFG, 32'h0);
    wr(A_CH0, 32'h0);
    i_det_front <= DW'(f);
    wr(A_CMD, 32'h4);
    run();
    rd(A_STAT, 32'h3, 32'h1);
    rd(A_STAMP0, '1, i_stamp);
    i_det_on <= 4'hE;
    wr(A_CMD, 32'h8);
    run();
    i_det_on <= 4'hF;
    rd(A_STAT, 32'h3, 32'h3);
    // Playback against each array
    wr(A_DCFG, 32'h100);
    i_run <= 1'b1;
    smp2();
    cmp(32'(s0), 0);
    i_run <= 1'b0;
    wr(A_DCFG, 32'h200);
    i_run <= 1'b1;
    smp2();
    cmp(32'(s0), f);
    i_run <= 1'b0;
    summarize();
  end
endmodule : oscx_tb_top
